// [core/loopback_biphase_consts.vh]
/*
 * Constants for the loopback and biphase transmit control block:
 * register byte addresses, field positions, reset values and mode codes.
 * Assumes inclusion by bare name from the core/ design files.
 */
`ifndef LOOPBACK_BIPHASE_CONSTS_VH
`define LOOPBACK_BIPHASE_CONSTS_VH

// register byte addresses on the apb window
`define ADDR_LOOPBACK_CONTROL 12'h000
`define ADDR_BIPHASE_TX_CONTROL 12'h004
`define ADDR_PORT_STATUS 12'h008
`define ADDR_WIDTH 12

// loopback_control fields
`define LB_ENABLE_BIT 0
`define LB_PAIR_DIR_BIT 1
`define LB_MODE_LO 2
`define LB_MODE_HI 3

// biphase_tx_control fields
`define BP_ENABLE_BIT 0
`define BP_LEFT_FLAG_BIT 2
`define BP_RIGHT_FLAG_BIT 3

// writable masks: bits 31..4 and biphase bit 1 stay zero
`define LB_WRITE_MASK 32'h0000000f
`define BP_WRITE_MASK 32'h0000000d

// reset values
`define LB_RESET 32'h00000000
`define BP_RESET 32'h00000000

// generator mode codes
`define GEN_MODE_DEFAULT 2'h0
`define GEN_MODE_SHARED_TX 2'h1

// status word fields
`define ST_LB_ACTIVE_BIT 0
`define ST_SHARED_GEN_BIT 1
`define ST_BIPHASE_BIT 2
`define ST_CHANGE_REFUSED_BIT 3
`define ST_BAD_MODE_BIT 4

// apb zero read data, also the answer sent with pslverr on unmapped reads
`define DATA_ZERO 32'h00000000

`endif

// [core/loopback_pair_router.v]
/*
 * Internal loopback router: pairs serializers two by two and, when loopback
 * is active, feeds each transmitter's output into its partner's receive input.
 * Assumes an even serializer count and same-clock inputs.
 */
`timescale 1ns/1ps
module loopback_pair_router #(
   parameter SERIALIZERS = 16
) (
   // clock and reset
   input wire clk_sys,
   input wire sys_rst,
   // controls
   input wire loopbackActive,
   input wire pairDirection,
   // serializer data
   input wire [SERIALIZERS-1:0] serTxData,
   input wire [SERIALIZERS-1:0] pinRxData,
   output reg [SERIALIZERS-1:0] serRxData,
   output reg [SERIALIZERS-1:0] serIsTransmitter
);

   genvar p;
   generate
      for (p = 0; p < SERIALIZERS / 2; p = p + 1) begin : pairs
         // per pair: loopback replaces the pin, never mixes with it
         always @(posedge clk_sys) begin
            if (sys_rst) begin
               serRxData[2*p] <= 1'b0;
               serRxData[2*p+1] <= 1'b0;
               serIsTransmitter[2*p] <= 1'b0;
               serIsTransmitter[2*p+1] <= 1'b0;
            end else if (loopbackActive && !pairDirection) begin
               serRxData[2*p] <= serTxData[2*p+1];
               serRxData[2*p+1] <= pinRxData[2*p+1];
               serIsTransmitter[2*p] <= 1'b0;
               serIsTransmitter[2*p+1] <= 1'b1;
            end else if (loopbackActive) begin
               serRxData[2*p] <= pinRxData[2*p];
               serRxData[2*p+1] <= serTxData[2*p];
               serIsTransmitter[2*p] <= 1'b1;
               serIsTransmitter[2*p+1] <= 1'b0;
            end else begin
               serRxData[2*p] <= pinRxData[2*p];
               serRxData[2*p+1] <= pinRxData[2*p+1];
               serIsTransmitter[2*p] <= 1'b0;
               serIsTransmitter[2*p+1] <= 1'b0;
            end
         end
      end
   endgenerate

endmodule

// [core/biphase_flag_select.v]
/*
 * Chooses the validity flag for the subframe being sent: even slots are the
 * left subframe, odd slots the right. Assumes the slot index is on clk_sys.
 */
`timescale 1ns/1ps
module biphase_flag_select #(
   parameter SLOT_WIDTH = 9
) (
   // clock and reset
   input wire clk_sys,
   input wire sys_rst,
   // settings
   input wire leftFlag,
   input wire rightFlag,
   input wire biphaseMode,
   // slot position
   input wire [SLOT_WIDTH-1:0] txSlot,
   output reg validFlag
);

   // flag only meaningful in biphase mode; otherwise held low
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         validFlag <= 1'b0;
      end else if (!biphaseMode) begin
         validFlag <= 1'b0;
      end else if (txSlot[0]) begin
         validFlag <= rightFlag;
      end else begin
         validFlag <= leftFlag;
      end
   end

endmodule

// [core/loopback_biphase_ctrl.v]
/*
 * Loopback and biphase transmit control: apb slave holding the loopback
 * control and biphase transmit control registers plus a status word, steering
 * the generator sharing, serializer pairing and transmit framing mode.
 * Assumes a single clk_sys domain; global release bits come from same-clock logic.
 */
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "loopback_biphase_consts.vh"
module loopback_biphase_ctrl #(
   parameter SERIALIZERS = 16,
   parameter SLOT_WIDTH = 9
) (
   // clock and reset
   input wire clk_sys,
   input wire sys_rst,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`ADDR_WIDTH-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // global release bits, same clock
   input wire txStateMachineRelease,
   input wire txSerializerRelease,
   input wire txClockDividerRelease,
   input wire txHfClockDividerRelease,
   // serializers
   input wire [SERIALIZERS-1:0] serTxData,
   input wire [SERIALIZERS-1:0] pinRxData,
   output wire [SERIALIZERS-1:0] serRxData,
   output wire [SERIALIZERS-1:0] serIsTransmitter,
   // transmit slot and framing
   input wire [SLOT_WIDTH-1:0] txSlot,
   output wire validFlag,
   output reg biphaseTransmitMode,
   output reg rxUsesTxGenerators,
   output reg loopbackActive
);

   reg [31:0] loopbackControl_reg;
   reg [31:0] biphaseTxControl_reg;
   reg changeRefused_reg;
   reg pairDirection_reg;
   reg [31:0] loopbackControl_next;
   reg [31:0] biphaseTxControl_next;
   reg changeRefused_next;
   reg [31:0] readData;
   reg addrHit;
   wire accessPhase;
   wire writeStrobe;
   wire [1:0] genMode;
   wire loopbackEnable;
   wire biphaseTxEnable;
   wire badMode;

   // address decode shared by read and write paths
   function [1:0] decodeAddr;
      input [`ADDR_WIDTH-1:0] a;
      begin
         if (a == `ADDR_LOOPBACK_CONTROL) begin
            decodeAddr = 2'h1;
         end else if (a == `ADDR_BIPHASE_TX_CONTROL) begin
            decodeAddr = 2'h2;
         end else if (a == `ADDR_PORT_STATUS) begin
            decodeAddr = 2'h3;
         end else begin
            decodeAddr = 2'h0;
         end
      end
   endfunction

   // one-wait-state slave: pready rises one cycle into the access phase
   assign accessPhase = psel && penable && !pready;
   // a write lands only at the edge where the master sees pready high, never a cycle early
   assign writeStrobe = psel && penable && pready && pwrite;

   assign loopbackEnable = loopbackControl_reg[`LB_ENABLE_BIT];
   assign genMode = loopbackControl_reg[`LB_MODE_HI:`LB_MODE_LO];
   assign biphaseTxEnable = biphaseTxControl_reg[`BP_ENABLE_BIT];
   // software slip flag: mode outside 01 while looped, or nonzero while not
   assign badMode = loopbackEnable ? (genMode != `GEN_MODE_SHARED_TX) : (genMode != `GEN_MODE_DEFAULT);

   // register write path; reserved bits masked away
   always @* begin
      loopbackControl_next = loopbackControl_reg;
      biphaseTxControl_next = biphaseTxControl_reg;
      changeRefused_next = changeRefused_reg;
      if (writeStrobe) begin
         if (decodeAddr(paddr) == 2'h1) begin
            loopbackControl_next = pwdata & `LB_WRITE_MASK;
         end else if (decodeAddr(paddr) == 2'h2) begin
            biphaseTxControl_next = pwdata & `BP_WRITE_MASK;
            // the enable is accepted regardless of clock divider state
            // a change while the state machine runs is still taken, but flagged
            if ((pwdata[`BP_ENABLE_BIT] != biphaseTxEnable) && txStateMachineRelease) begin
               changeRefused_next = 1'b1;
            end
         end else if (decodeAddr(paddr) == 2'h3) begin
            // writing status with bit 3 set clears the sticky flag; the other status bits have no effect
            if (pwdata[`ST_CHANGE_REFUSED_BIT]) begin
               changeRefused_next = 1'b0;
            end
         end
      end
   end

   // read mux; unmapped addresses read zero and answer with pslverr
   always @* begin
      readData = `DATA_ZERO;
      addrHit = 1'b1;
      if (decodeAddr(paddr) == 2'h1) begin
         readData = loopbackControl_reg;
      end else if (decodeAddr(paddr) == 2'h2) begin
         readData = biphaseTxControl_reg;
      end else if (decodeAddr(paddr) == 2'h3) begin
         readData[`ST_LB_ACTIVE_BIT] = loopbackActive;
         readData[`ST_SHARED_GEN_BIT] = rxUsesTxGenerators;
         readData[`ST_BIPHASE_BIT] = biphaseTransmitMode;
         readData[`ST_CHANGE_REFUSED_BIT] = changeRefused_reg;
         readData[`ST_BAD_MODE_BIT] = badMode;
      end else begin
         addrHit = 1'b0;
      end
   end

   // apb handshake and register state
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         loopbackControl_reg <= `LB_RESET;
         biphaseTxControl_reg <= `BP_RESET;
         changeRefused_reg <= 1'b0;
         prdata <= `DATA_ZERO;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         loopbackControl_reg <= loopbackControl_next;
         biphaseTxControl_reg <= biphaseTxControl_next;
         changeRefused_reg <= changeRefused_next;
         pready <= accessPhase;
         pslverr <= accessPhase && !addrHit;
         if (accessPhase && !pwrite) begin
            prdata <= readData;
         end else begin
            prdata <= `DATA_ZERO;
         end
      end
   end

   // effective controls, registered so outputs come from flip-flops
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         loopbackActive <= 1'b0;
         rxUsesTxGenerators <= 1'b0;
         biphaseTransmitMode <= 1'b0;
         pairDirection_reg <= 1'b0;
      end else begin
         loopbackActive <= loopbackEnable;
         // mode ignored unless loopback is on only 1h shares generators
         rxUsesTxGenerators <= loopbackEnable && (genMode == `GEN_MODE_SHARED_TX);
         // set: biphase framing clear: tdm or burst framing
         biphaseTransmitMode <= biphaseTxEnable;
         pairDirection_reg <= loopbackControl_reg[`LB_PAIR_DIR_BIT];
      end
   end

   // serializer pairing and internal data path
   loopback_pair_router #(
      .SERIALIZERS(SERIALIZERS)
   ) router (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .loopbackActive(loopbackActive),
      .pairDirection(pairDirection_reg),
      .serTxData(serTxData),
      .pinRxData(pinRxData),
      .serRxData(serRxData),
      .serIsTransmitter(serIsTransmitter)
   );

   // subframe validity flag
   biphase_flag_select #(
      .SLOT_WIDTH(SLOT_WIDTH)
   ) flags (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .leftFlag(biphaseTxControl_reg[`BP_LEFT_FLAG_BIT]),
      .rightFlag(biphaseTxControl_reg[`BP_RIGHT_FLAG_BIT]),
      .biphaseMode(biphaseTransmitMode),
      .txSlot(txSlot),
      .validFlag(validFlag)
   );

endmodule

// [test/loopback_biphase_monitor.sv]
/* checker for loopback_biphase_ctrl: apb answer timing, control levels,
   serializer pairing and validity flag. assumes one clk_sys domain. */
`timescale 1ns/1ps
`include "loopback_biphase_consts.vh"
module loopback_biphase_monitor #(
   parameter SERIALIZERS = 16,
   parameter SLOT_WIDTH = 9
) (
   // clock and reset
   input wire clk_sys,
   input wire sys_rst,
   // apb
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`ADDR_WIDTH-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // serializers and framing
   input wire [SERIALIZERS-1:0] serTxData,
   input wire [SERIALIZERS-1:0] pinRxData,
   input wire [SERIALIZERS-1:0] serRxData,
   input wire [SERIALIZERS-1:0] serIsTransmitter,
   input wire [SLOT_WIDTH-1:0] txSlot,
   input wire validFlag,
   input wire biphaseTransmitMode,
   input wire rxUsesTxGenerators,
   input wire loopbackActive
);
   wire tk = psel && penable && !pready;
   wire wrLb = tk && pwrite && paddr == `ADDR_LOOPBACK_CONTROL;
   wire wrBp = tk && pwrite && paddr == `ADDR_BIPHASE_TX_CONTROL;
   reg [1:0] quiet;
   reg [2:0] sh;
   // shadow of flags and direction; quiet waits out the control pipeline
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         quiet <= 2'h0;
         sh <= 3'h0;
      end else begin
         quiet <= tk ? 2'h0 : (quiet == 2'h3 ? quiet : quiet + 2'h1);
         if (wrLb) sh[0] <= pwdata[1];
         if (wrBp) sh[2:1] <= pwdata[3:2];
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   AST_ONE_WAIT: assert property (tk |=> pready)
      else $error("access not answered after one wait state");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   AST_UNMAPPED: assert property (tk && paddr > 12'h008 |=> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   AST_LB_ENABLE: assert property (wrLb |=> ##2 loopbackActive == $past(pwdata[0], 3))
      else $error("loopback level does not follow enable bit");
   AST_SHARED_GEN: assert property (wrLb |=> ##2 rxUsesTxGenerators ==
      ($past(pwdata[0], 3) && $past(pwdata[3:2], 3) == `GEN_MODE_SHARED_TX))
      else $error("generator sharing wrong");
   AST_BIPHASE: assert property (wrBp |=> ##2 biphaseTransmitMode == $past(pwdata[0], 3))
      else $error("biphase mode does not follow enable bit");
   AST_VALID_FLAG: assert property (quiet == 2'h3 |-> validFlag ==
      ($past(biphaseTransmitMode) && ($past(txSlot[0]) ? sh[2] : sh[1])))
      else $error("validity flag wrong for slot");
   AST_PAIR_ODD: assert property (quiet == 2'h3 && $past(loopbackActive) && !sh[0] |->
      serRxData[0] == $past(serTxData[1]) && serIsTransmitter[1:0] == 2'b10)
      else $error("odd to even pairing wrong");
   AST_PAIR_EVEN: assert property (quiet == 2'h3 && $past(loopbackActive) && sh[0] |->
      serRxData[1] == $past(serTxData[0]) && serIsTransmitter[1:0] == 2'b01)
      else $error("even to odd pairing wrong");
   AST_NO_LOOP: assert property (quiet == 2'h3 && !$past(loopbackActive) |->
      serRxData == $past(pinRxData) && serIsTransmitter == '0)
      else $error("pins not passed through without loopback");
   cover property (wrLb && pwdata[0] && pwdata[3:2] == 2'h1);
   cover property (biphaseTransmitMode && validFlag);
   cover property (pslverr);
endmodule
bind loopback_biphase_ctrl loopback_biphase_monitor #(.SERIALIZERS(SERIALIZERS), .SLOT_WIDTH(SLOT_WIDTH)) u_mon (
   .clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .serTxData, .pinRxData, .serRxData, .serIsTransmitter, .txSlot, .validFlag,
   .biphaseTransmitMode, .rxUsesTxGenerators, .loopbackActive);

// [test/loopback_and_biphase_tx_control_tb.sv]
/* random register traffic against a register model, output levels checked
   after every write. assumes the checker is bound to the design. */
`timescale 1ns/1ps
`include "loopback_biphase_consts.vh"
module loopback_and_biphase_tx_control_tb;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, relSm = 1'b0, e;
   logic [2:0] relOther = 3'h0;
   logic [11:0] paddr = 12'h000, a;
   logic [31:0] pwdata = 32'h0, prdata, lb, bp, q, d;
   logic pready, pslverr, validFlag, biphaseTransmitMode, rxUsesTxGenerators, loopbackActive, sticky;
   logic [15:0] serTxData = 16'h0, pinRxData = 16'h0, serRxData, serIsTransmitter;
   logic [8:0] txSlot = 9'h000, sl;
   logic [15:0] st, pr, er, et;
   int mismatches = 0, comparisons = 0, n;
   always #50 clk_sys = ~clk_sys;
   loopback_biphase_ctrl u_dut (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .txStateMachineRelease(relSm), .txSerializerRelease(relOther[0]),
      .txClockDividerRelease(relOther[1]), .txHfClockDividerRelease(relOther[2]), .serTxData,
      .pinRxData, .serRxData, .serIsTransmitter, .txSlot, .validFlag, .biphaseTransmitMode,
      .rxUsesTxGenerators, .loopbackActive);
   // serializer traffic and slot count are free random streams; roles are taken as set up
   always @(posedge clk_sys) begin
      serTxData <= 16'($urandom);
      pinRxData <= 16'($urandom);
      txSlot <= 9'($urandom);
      relOther <= 3'($urandom);
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one apb transfer; waits on pready, bounded so a hang counts as a miss
   task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) mismatches++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [31:0] expRd(input logic [11:0] ad);
      if (ad == `ADDR_LOOPBACK_CONTROL) return lb;
      if (ad == `ADDR_BIPHASE_TX_CONTROL) return bp;
      if (ad == `ADDR_PORT_STATUS)
         return {27'h0, lb[0] ? lb[3:2] != 2'h1 : lb[3:2] != 2'h0, sticky, bp[0], lb[0] && lb[3:2] == 2'h1, lb[0]};
      return 32'h0;
   endfunction
   task tally_and_finish;
      if (mismatches == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // watchdog well beyond the roughly 900 cycles the run needs
   initial begin
      #(100 * 20000);
      mismatches++;
      tally_and_finish;
   end
   // main sequence: reset values, then random writes, read-backs, one mid-run reset
   initial begin
      void'($urandom(97));
      lb = `LB_RESET;
      bp = `BP_RESET;
      sticky = 1'b0;
      repeat (8) @(posedge clk_sys);
      sys_rst <= 1'b0;
      for (int i = 0; i < 90; i++) begin
         if (i == 45) begin
            sys_rst <= 1'b1;
            repeat (2) @(posedge clk_sys);
            sys_rst <= 1'b0;
            lb = `LB_RESET;
            bp = `BP_RESET;
            sticky = 1'b0;
         end
         a = 12'(($urandom % 4) * 4);
         d = $urandom;
         if (i % 2 == 0) d = d & 32'h0000000f;
         if (a == `ADDR_LOOPBACK_CONTROL) d[3:2] = d[0] ? `GEN_MODE_SHARED_TX : `GEN_MODE_DEFAULT;
         relSm <= (a == `ADDR_BIPHASE_TX_CONTROL && d[0] != bp[0]) ? 1'b0 : 1'($urandom);
         apb(1'b0, a, 32'h0);
         chk(q, expRd(a));
         apb(1'b1, a, d);
         chk({31'h0, e}, {31'h0, a == 12'h00c});
         if (a == `ADDR_LOOPBACK_CONTROL) lb = d & `LB_WRITE_MASK;
         if (a == `ADDR_BIPHASE_TX_CONTROL) begin
            if (relSm && d[0] != bp[0]) sticky = 1'b1;
            bp = d & `BP_WRITE_MASK;
         end
         if (a == `ADDR_PORT_STATUS && d[3]) sticky = 1'b0;
         // write lands at the pready edge, control levels one edge later
         @(posedge clk_sys);
         #1;
         chk({29'h0, loopbackActive, rxUsesTxGenerators, biphaseTransmitMode},
            {29'h0, lb[0], lb[0] && lb[3:2] == 2'h1, bp[0]});
         st = serTxData;
         pr = pinRxData;
         sl = txSlot;
         @(posedge clk_sys);
         #1;
         for (int p = 0; p < 8; p++) begin
            er[2*p] = (lb[0] && !lb[1]) ? st[2*p+1] : pr[2*p];
            er[2*p+1] = (lb[0] && lb[1]) ? st[2*p] : pr[2*p+1];
            et[2*p] = lb[0] && lb[1];
            et[2*p+1] = lb[0] && !lb[1];
         end
         chk({16'h0, serRxData}, {16'h0, er});
         chk({16'h0, serIsTransmitter}, {16'h0, et});
         chk({31'h0, validFlag}, {31'h0, bp[0] && (sl[0] ? bp[3] : bp[2])});
      end
      tally_and_finish;
   end
endmodule
